/* File: rtl/ptp_rate_pkg.sv */
// constants for the precision-time clock with rate adjustment
// assumes a 25 MHz system clock and a 32-bit Avalon-MM register port
package ptp_rate_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices: byte address is four times the index
    localparam int            IDX_W        = 14;
    localparam logic [13:0]   IDX_CTRL     = 14'h0500;
    localparam logic [13:0]   IDX_PHASE    = 14'h0502;
    localparam logic [13:0]   IDX_NS_HI    = 14'h0504;
    localparam logic [13:0]   IDX_NS_LO    = 14'h0506;
    localparam logic [13:0]   IDX_SEC_HI   = 14'h0508;
    localparam logic [13:0]   IDX_SEC_LO   = 14'h050a;
    localparam logic [13:0]   IDX_RATE_HI  = 14'h050c;
    localparam logic [13:0]   IDX_RATE_LO  = 14'h050e;
    localparam logic [13:0]   IDX_DUR_HI   = 14'h0510;
    localparam logic [13:0]   IDX_DUR_LO   = 14'h0512;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int            CTRL_RESET   = 0;
    localparam int            CTRL_ENABLE  = 1;
    localparam int            CTRL_CONT    = 2;
    localparam int            CTRL_LOAD    = 3;
    localparam int            CTRL_READ    = 4;
    localparam int            RATE_DIR     = 15;
    localparam int            RATE_TEMP    = 14;
    localparam int            RATE_HI_W    = 14;
    localparam int            RATE_W       = 30;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0]   WORD_RST     = 16'h0000;
    localparam logic [2:0]    PHASE_RST    = 3'h0;
    localparam logic [31:0]   WAIT_RST     = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // timing: one tick is one clock period
    localparam int            CLK_PERIOD_NS = 40;
    localparam int            PHASE_STEP_NS = 8;
    localparam logic [2:0]    PHASE_LAST    = 3'(CLK_PERIOD_NS / PHASE_STEP_NS - 1);
    localparam logic [31:0]   TICK_NS       = 32'(CLK_PERIOD_NS);
    localparam logic [32:0]   NS_PER_SEC    = 33'h0_3b9a_ca00;

endpackage : ptp_rate_pkg

/* File: rtl/ptp_time_if.sv */
// time-core control and status bundle between register file and core
// assumes both ends share one clock
`timescale 1ns/100ps
interface ptp_time_if;
    logic        runEnable;
    logic        adjustOn;
    logic        addDir;
    logic [29:0] rate;
    logic        loadStrobe;
    logic        clearStrobe;
    logic [31:0] loadNs;
    logic [31:0] loadSec;
    logic [31:0] ns;
    logic [31:0] sec;

    modport ctrl (output runEnable, adjustOn, addDir, rate, loadStrobe,
                  clearStrobe, loadNs, loadSec, input ns, sec);
    modport core (input runEnable, adjustOn, addDir, rate, loadStrobe,
                  clearStrobe, loadNs, loadSec, output ns, sec);
endinterface : ptp_time_if

/* File: rtl/ptp_time_core.sv */
// running time of day: seconds, nanoseconds and a 30-bit ns fraction
// assumes control strobes are single-cycle and synchronous to clk
`timescale 1ns/100ps
module ptp_time_core (
    input  wire logic  clk,
    input  wire logic  rst_n,
    ptp_time_if.core   tif
);
    logic [31:0] ns_ff;
    logic [31:0] sec_ff;
    logic [29:0] frac_ff;

    ////////////////////////////////////////////////////////////////////////
    // fraction first; its carry or borrow nudges the 40 ns step by one ns
    wire  [30:0] fracAdd = {1'b0, frac_ff} + {1'b0, tif.rate};
    wire  [30:0] fracSub = {1'b0, frac_ff} - {1'b0, tif.rate};
    wire         upStep  = tif.adjustOn && tif.addDir && fracAdd[30];
    wire         dnStep  = tif.adjustOn && !tif.addDir && fracSub[30];
    wire  [29:0] nxt_frac = !tif.adjustOn ? frac_ff :
                            (tif.addDir ? fracAdd[29:0] : fracSub[29:0]);
    // step never drops below 39 ns, so nanoseconds never underflow
    wire  [31:0] nsStep  = ptp_rate_pkg::TICK_NS + 32'(upStep) - 32'(dnStep);
    wire  [32:0] nsSum   = {1'b0, ns_ff} + {1'b0, nsStep};
    wire         nsWrap  = nsSum >= ptp_rate_pkg::NS_PER_SEC;
    wire  [32:0] nsFold  = nsSum - ptp_rate_pkg::NS_PER_SEC;
    wire  [31:0] nxt_ns  = nsWrap ? nsFold[31:0] : nsSum[31:0];
    wire  [31:0] nxt_sec = sec_ff + 32'(nsWrap);

    // clear beats load, load beats running
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ns_ff   <= '0;
            sec_ff  <= '0;
            frac_ff <= '0;
        end
        else if (tif.clearStrobe)
        begin
            ns_ff   <= '0;
            sec_ff  <= '0;
            frac_ff <= '0;
        end
        else if (tif.loadStrobe)
        begin
            ns_ff   <= tif.loadNs;
            sec_ff  <= tif.loadSec;
            frac_ff <= '0;
        end
        else if (tif.runEnable)
        begin
            ns_ff   <= nxt_ns;
            sec_ff  <= nxt_sec;
            frac_ff <= nxt_frac;
        end
    end

    assign tif.ns  = ns_ff;
    assign tif.sec = sec_ff;

    ////////////////////////////////////////////////////////////////////////
    wire plainRun = tif.runEnable && !tif.loadStrobe && !tif.clearStrobe;

    add_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
        plainRun && tif.adjustOn && tif.addDir
        |=> frac_ff == 30'($past(frac_ff) + $past(tif.rate)))
        else $error("fraction did not grow by the rate");
    sub_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
        plainRun && tif.adjustOn && !tif.addDir
        |=> frac_ff == 30'($past(frac_ff) - $past(tif.rate)))
        else $error("fraction did not shrink by the rate");
    clock_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        tif.loadStrobe && !tif.clearStrobe
        |=> ns_ff == $past(tif.loadNs) && sec_ff == $past(tif.loadSec))
        else $error("clock not loaded from registers");
    sec_roll_c: cover property (@(posedge clk) disable iff (!rst_n)
        plainRun && nsWrap);
endmodule : ptp_time_core

/* File: rtl/ptp_clock_rate_adjust.sv */
// register file and adjustment control for the precision-time clock
// assumes Avalon-MM master on clk; byte address, registers on word slots
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps

module ptp_clock_rate_adjust (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic      [31:0] clockNs,
    output logic      [31:0] clockSec,
    output logic             tempActive
);
    ptp_time_if tif ();

    ptp_time_core u_core (
        .clk   (clk),
        .rst_n (rst_n),
        .tif   (tif)
    );

    ////////////////////////////////////////////////////////////////////////
    // byte-lane merge for the 16-bit words in the low lanes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    logic        waitReq_ff;
    logic [31:0] rdData_ff;
    logic [15:0] nsHi_ff;
    logic [15:0] nsLo_ff;
    logic [15:0] secHi_ff;
    logic [15:0] secLo_ff;
    logic [2:0]  phase_ff;
    logic [2:0]  runPhase_ff;
    logic        rateDir_ff;
    logic [13:0] rateHi_ff;
    logic [15:0] rateLo_ff;
    logic [15:0] durHi_ff;
    logic [15:0] durLo_ff;
    logic        runEn_ff;
    logic        contAdj_ff;
    logic        tempOn_ff;
    logic [31:0] tempCnt_ff;

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: waitrequest drops for one cycle, the access lands then
    wire        request  = read || write;
    wire        accept   = request && !waitReq_ff;
    wire        wrAcc    = accept && write;
    wire [13:0] idx      = address[15:2];
    wire        aligned  = address[1:0] == 2'h0;

    // address decode
    wire hitCtrl   = aligned && idx == ptp_rate_pkg::IDX_CTRL;
    wire hitPhase  = aligned && idx == ptp_rate_pkg::IDX_PHASE;
    wire hitNsHi   = aligned && idx == ptp_rate_pkg::IDX_NS_HI;
    wire hitNsLo   = aligned && idx == ptp_rate_pkg::IDX_NS_LO;
    wire hitSecHi  = aligned && idx == ptp_rate_pkg::IDX_SEC_HI;
    wire hitSecLo  = aligned && idx == ptp_rate_pkg::IDX_SEC_LO;
    wire hitRateHi = aligned && idx == ptp_rate_pkg::IDX_RATE_HI;
    wire hitRateLo = aligned && idx == ptp_rate_pkg::IDX_RATE_LO;
    wire hitDurHi  = aligned && idx == ptp_rate_pkg::IDX_DUR_HI;
    wire hitDurLo  = aligned && idx == ptp_rate_pkg::IDX_DUR_LO;

    // control writes; self-clearing bits act only at the accepting edge
    wire [15:0] wrWord   = merge16(16'h0000, writedata, byteenable);
    wire        ctrlWr   = wrAcc && hitCtrl;
    wire        doClear  = ctrlWr && byteenable[0] && wrWord[ptp_rate_pkg::CTRL_RESET];
    wire        doLoad   = ctrlWr && byteenable[0] && wrWord[ptp_rate_pkg::CTRL_LOAD];
    wire        doCapt   = ctrlWr && byteenable[0] && wrWord[ptp_rate_pkg::CTRL_READ];
    wire        rateHiWr = wrAcc && hitRateHi && byteenable[1];
    wire        tempGo   = rateHiWr && writedata[ptp_rate_pkg::RATE_TEMP];
    wire        tempStop = rateHiWr && !writedata[ptp_rate_pkg::RATE_TEMP];
    wire        tempLast = tempOn_ff && tempCnt_ff == 32'h0000_0001;
    wire [31:0] durAll   = {durHi_ff, durLo_ff};
    wire [15:0] phaseNew = merge16({13'h0000, phase_ff}, writedata, byteenable);
    // rate high merged as a full word; only 13:0 is kept, 15 and 14 are handled apart
    wire [15:0] rateHiNew = merge16({2'h0, rateHi_ff}, writedata, byteenable);
    // codes above the fifth phase are refused, the old code stays
    wire        phaseOk  = phaseNew[2:0] <= ptp_rate_pkg::PHASE_LAST;

    // read selection, unmapped and reserved bits read zero
    wire [15:0] ctrlRd   = {13'h0000, contAdj_ff, runEn_ff, 1'b0};
    wire [15:0] rateHiRd = {rateDir_ff, tempOn_ff, rateHi_ff};
    wire [15:0] rdMux    = hitCtrl   ? ctrlRd :
                           hitPhase  ? {13'h0000, phase_ff} :
                           hitNsHi   ? nsHi_ff :
                           hitNsLo   ? nsLo_ff :
                           hitSecHi  ? secHi_ff :
                           hitSecLo  ? secLo_ff :
                           hitRateHi ? rateHiRd :
                           hitRateLo ? rateLo_ff :
                           hitDurHi  ? durHi_ff :
                           hitDurLo  ? durLo_ff : 16'h0000;

    // drive the time core
    assign tif.runEnable   = runEn_ff;
    assign tif.adjustOn    = contAdj_ff || tempOn_ff;
    assign tif.addDir      = rateDir_ff;
    assign tif.rate        = {rateHi_ff, rateLo_ff};
    assign tif.loadStrobe  = doLoad;
    assign tif.clearStrobe = doClear;
    assign tif.loadNs      = {nsHi_ff, nsLo_ff};
    assign tif.loadSec     = {secHi_ff, secLo_ff};

    ////////////////////////////////////////////////////////////////////////
    // bus answer registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitReq_ff <= 1'b1;
            rdData_ff  <= ptp_rate_pkg::WAIT_RST;
        end
        else
        begin
            waitReq_ff <= !(waitReq_ff && request);
            if (waitReq_ff && read)
                rdData_ff <= {16'h0000, rdMux};
        end
    end

    // time words: a capture overwrites them from the live clock
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nsHi_ff  <= ptp_rate_pkg::WORD_RST;
            nsLo_ff  <= ptp_rate_pkg::WORD_RST;
            secHi_ff <= ptp_rate_pkg::WORD_RST;
            secLo_ff <= ptp_rate_pkg::WORD_RST;
            phase_ff <= ptp_rate_pkg::PHASE_RST;
        end
        else if (doCapt)
        begin
            {nsHi_ff, nsLo_ff}   <= tif.ns;
            {secHi_ff, secLo_ff} <= tif.sec;
            phase_ff             <= runPhase_ff;
        end
        else if (wrAcc)
        begin
            if (hitNsHi)
                nsHi_ff <= merge16(nsHi_ff, writedata, byteenable);
            if (hitNsLo)
                nsLo_ff <= merge16(nsLo_ff, writedata, byteenable);
            if (hitSecHi)
                secHi_ff <= merge16(secHi_ff, writedata, byteenable);
            if (hitSecLo)
                secLo_ff <= merge16(secLo_ff, writedata, byteenable);
            if (hitPhase && phaseOk)
                phase_ff <= phaseNew[2:0];
        end
    end

    // sub-phase of the running clock, taken from the phase word at load
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            runPhase_ff <= ptp_rate_pkg::PHASE_RST;
        else if (doClear)
            runPhase_ff <= ptp_rate_pkg::PHASE_RST;
        else if (doLoad)
            runPhase_ff <= phase_ff;
    end

    // rate, duration and control enables
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rateDir_ff <= 1'b0;
            rateHi_ff  <= '0;
            rateLo_ff  <= ptp_rate_pkg::WORD_RST;
            durHi_ff   <= ptp_rate_pkg::WORD_RST;
            durLo_ff   <= ptp_rate_pkg::WORD_RST;
            runEn_ff   <= 1'b0;
            contAdj_ff <= 1'b0;
        end
        else if (wrAcc)
        begin
            if (hitRateHi)
            begin
                rateHi_ff <= rateHiNew[13:0];
                if (byteenable[1])
                    rateDir_ff <= writedata[ptp_rate_pkg::RATE_DIR];
            end
            if (hitRateLo)
                rateLo_ff <= merge16(rateLo_ff, writedata, byteenable);
            if (hitDurHi)
                durHi_ff <= merge16(durHi_ff, writedata, byteenable);
            if (hitDurLo)
                durLo_ff <= merge16(durLo_ff, writedata, byteenable);
            if (hitCtrl && byteenable[0])
            begin
                runEn_ff   <= wrWord[ptp_rate_pkg::CTRL_ENABLE];
                contAdj_ff <= wrWord[ptp_rate_pkg::CTRL_CONT];
            end
        end
    end

    // temporary adjustment: a software start wins over the count expiring
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tempOn_ff  <= 1'b0;
            tempCnt_ff <= '0;
        end
        else if (tempGo)
        begin
            tempOn_ff  <= durAll != 32'h0000_0000;
            tempCnt_ff <= durAll;
        end
        else if (tempStop)
        begin
            tempOn_ff  <= 1'b0;
            tempCnt_ff <= '0;
        end
        else if (tempOn_ff)
        begin
            tempOn_ff  <= !tempLast;
            tempCnt_ff <= tempCnt_ff - 32'h0000_0001;
        end
    end

    // outputs straight from flip-flops
    assign readdata    = rdData_ff;
    assign waitrequest = waitReq_ff;
    assign clockNs     = tif.ns;
    assign clockSec    = tif.sec;
    assign tempActive  = tempOn_ff;

    ////////////////////////////////////////////////////////////////////////
    wire fullWr = wrAcc && byteenable[1:0] == 2'h3;

    ns_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        fullWr && hitNsLo && !doCapt |=> nsLo_ff == $past(writedata[15:0]))
        else $error("nanosecond low word not written");
    sec_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        fullWr && hitSecHi |=> secHi_ff == $past(writedata[15:0]))
        else $error("seconds high word not written");
    sec_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        fullWr && hitSecLo |=> secLo_ff == $past(writedata[15:0]))
        else $error("seconds low word not written");
    temp_end_a: assert property (@(posedge clk) disable iff (!rst_n)
        tempLast && !rateHiWr |=> !tempOn_ff && tempCnt_ff == 32'h0000_0000)
        else $error("temporary adjustment did not end");
    temp_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        tempStop |=> !tempOn_ff && tif.adjustOn == contAdj_ff)
        else $error("temporary adjustment not stopped");
    temp_run_a: assert property (@(posedge clk) disable iff (!rst_n)
        tempGo && durAll == 32'h0000_0005 |=> tempOn_ff [*5] ##1 !tempOn_ff)
        else $error("temporary adjustment length wrong");
    rate_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        fullWr && hitRateLo |=> tif.rate[15:0] == $past(writedata[15:0]))
        else $error("rate low word not in use");
    rate_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        fullWr && hitRateHi |=> tif.rate[29:16] == $past(writedata[13:0]))
        else $error("rate high field not in use");
    capture_a: assert property (@(posedge clk) disable iff (!rst_n)
        doCapt |=> {nsHi_ff, nsLo_ff} == $past(tif.ns)
                   && {secHi_ff, secLo_ff} == $past(tif.sec))
        else $error("clock not captured");
    phase_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        phase_ff <= ptp_rate_pkg::PHASE_LAST && runPhase_ff <= ptp_rate_pkg::PHASE_LAST)
        else $error("phase code out of range");
    cont_adj_a: assert property (@(posedge clk) disable iff (!rst_n)
        contAdj_ff |-> tif.adjustOn)
        else $error("continuous adjustment not applied");
    bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
        waitReq_ff && request |=> !waitrequest ##1 waitrequest)
        else $error("bus answer timing wrong");

    temp_done_c: cover property (@(posedge clk) disable iff (!rst_n) tempLast);
    capt_c:      cover property (@(posedge clk) disable iff (!rst_n) doCapt);
    load_c:      cover property (@(posedge clk) disable iff (!rst_n) doLoad);
    cont_sub_c:  cover property (@(posedge clk) disable iff (!rst_n)
        contAdj_ff && runEn_ff && !rateDir_ff);
endmodule : ptp_clock_rate_adjust

/* File: tb/test_ptp_clock_rate_adjust.sv */
// self-checking bench for the clock register file and rate adjustment
// assumes the dut answers each Avalon-MM access after one wait cycle
`timescale 1ns/100ps
module test_ptp_clock_rate_adjust;
    logic        clk;
    logic        rst_n;
    logic [15:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [31:0] clockNs;
    logic [31:0] clockSec;
    logic        tempActive;
    int          errors;
    int          compares;
    int          tempCount;
    logic [15:0] rdWord;
    logic [31:0] nsMark;
    logic [13:0] regIdx [7] = '{ptp_rate_pkg::IDX_NS_LO, ptp_rate_pkg::IDX_SEC_HI,
        ptp_rate_pkg::IDX_SEC_LO, ptp_rate_pkg::IDX_RATE_HI, ptp_rate_pkg::IDX_RATE_LO,
        ptp_rate_pkg::IDX_DUR_HI, ptp_rate_pkg::IDX_DUR_LO};

    ptp_clock_rate_adjust dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .clockNs(clockNs), .clockSec(clockSec),
        .tempActive(tempActive));

    ////////////////////////////////////////////////////////////////////////
    // clock and a running count of cycles with temporary adjustment on
    initial clk = 1'b0;
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        if (tempActive === 1'b1) tempCount++;
    end

    ////////////////////////////////////////////////////////////////////////
    // verdict, comparison and bus tasks
    task automatic test_done();
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is sampled low; bounded so a hang ends the run
    task automatic busOp(input logic wr, input logic [15:0] addr, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        read       <= ~wr;
        write      <= wr;
        address    <= addr;
        writedata  <= {16'h0000, wd};
        byteenable <= 4'hf;
        do
        begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rdWord = readdata[15:0];
        read  <= 1'b0;
        write <= 1'b0;
        if (n >= 20)
        begin
            errors++;
            test_done();
        end
    endtask

    task automatic wr(input logic [13:0] idx, input logic [15:0] wd);
        busOp(1'b1, {idx, 2'b00}, wd);
    endtask

    task automatic rdCheck(input logic [13:0] idx, input logic [15:0] exp);
        busOp(1'b0, {idx, 2'b00}, 16'h0000);
        check({16'h0000, rdWord}, {16'h0000, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic resetAndReadWrite();
        logic [15:0] pat;
        for (int i = 0; i < 7; i++) rdCheck(regIdx[i], 16'h0000);
        for (int i = 0; i < 7; i++)
        begin
            pat = 16'h1234 + 16'(i) * 16'h1111;
            wr(regIdx[i], pat);
            // temporary bit reads back as idle since the duration is still zero
            rdCheck(regIdx[i], (i == 3) ? (pat & 16'hbfff) : pat);
        end
        wr(14'h0600, 16'hffff);
        rdCheck(14'h0600, 16'h0000);
        busOp(1'b0, 16'h1419, 16'h0000);
        check({16'h0000, rdWord}, 32'h0000_0000);
    endtask

    // loaded value must reach the live outputs and come back on capture
    task automatic loadAndCapture();
        wr(ptp_rate_pkg::IDX_NS_HI, 16'h0000);
        wr(ptp_rate_pkg::IDX_NS_LO, 16'h03e8);
        wr(ptp_rate_pkg::IDX_SEC_HI, 16'h0001);
        wr(ptp_rate_pkg::IDX_SEC_LO, 16'h0002);
        wr(ptp_rate_pkg::IDX_CTRL, 16'h0008);
        repeat (2) @(posedge clk);
        check(clockNs, 32'h0000_03e8);
        check(clockSec, 32'h0001_0002);
        wr(ptp_rate_pkg::IDX_NS_LO, 16'h5555);
        wr(ptp_rate_pkg::IDX_CTRL, 16'h0010);
        rdCheck(ptp_rate_pkg::IDX_NS_LO, 16'h03e8);
        rdCheck(ptp_rate_pkg::IDX_SEC_LO, 16'h0002);
    endtask

    // half a nanosecond per cycle: 20 cycles give 800 ns plus or minus 10
    task automatic continuousRun(input logic [15:0] rateHi, input logic [31:0] expDelta);
        wr(ptp_rate_pkg::IDX_RATE_LO, 16'h0000);
        wr(ptp_rate_pkg::IDX_RATE_HI, rateHi);
        wr(ptp_rate_pkg::IDX_CTRL, 16'h0006);
        repeat (2) @(posedge clk);
        nsMark = clockNs;
        repeat (20) @(posedge clk);
        check(clockNs - nsMark, expDelta);
        wr(ptp_rate_pkg::IDX_CTRL, 16'h0002);
    endtask

    task automatic temporaryRun();
        wr(ptp_rate_pkg::IDX_DUR_HI, 16'h0000);
        wr(ptp_rate_pkg::IDX_DUR_LO, 16'h0005);
        tempCount = 0;
        wr(ptp_rate_pkg::IDX_RATE_HI, 16'he000);
        repeat (20) @(posedge clk);
        check(32'(tempCount), 32'h0000_0005);
        rdCheck(ptp_rate_pkg::IDX_RATE_HI, 16'ha000);
        // a long run cut short by writing the temporary bit back to zero
        wr(ptp_rate_pkg::IDX_DUR_LO, 16'h0064);
        wr(ptp_rate_pkg::IDX_RATE_HI, 16'he000);
        repeat (3) @(posedge clk);
        check({31'h0, tempActive}, 32'h0000_0001);
        wr(ptp_rate_pkg::IDX_RATE_HI, 16'ha000);
        repeat (2) @(posedge clk);
        check({31'h0, tempActive}, 32'h0000_0000);
    endtask

    // phase codes past the fifth are refused; a load takes the phase, a clear zeroes it
    task automatic phaseAndClear();
        wr(ptp_rate_pkg::IDX_PHASE, 16'h0003);
        wr(ptp_rate_pkg::IDX_PHASE, 16'h0006);
        rdCheck(ptp_rate_pkg::IDX_PHASE, 16'h0003);
        wr(ptp_rate_pkg::IDX_CTRL, 16'h000a);
        wr(ptp_rate_pkg::IDX_PHASE, 16'h0000);
        wr(ptp_rate_pkg::IDX_CTRL, 16'h0012);
        rdCheck(ptp_rate_pkg::IDX_PHASE, 16'h0003);
        wr(ptp_rate_pkg::IDX_CTRL, 16'h0001);
        wr(ptp_rate_pkg::IDX_CTRL, 16'h0010);
        rdCheck(ptp_rate_pkg::IDX_PHASE, 16'h0000);
        rdCheck(ptp_rate_pkg::IDX_NS_LO, 16'h0000);
        rdCheck(ptp_rate_pkg::IDX_SEC_LO, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset held for 20 cycles, then every scenario in turn
    initial
    begin
        errors = 0;
        compares = 0;
        tempCount = 0;
        rst_n = 1'b0;
        address = 16'h0000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        resetAndReadWrite();
        loadAndCapture();
        continuousRun(16'ha000, 32'h0000_032a);
        continuousRun(16'h2000, 32'h0000_0316);
        temporaryRun();
        phaseAndClear();
        test_done();
    end
endmodule // test_ptp_clock_rate_adjust
